// ### logic/line_loss_cfg.svh
// offsets, fields, reset values and timing counts of the line loss block
`ifndef LINE_LOSS_CFG_SVH
`define LINE_LOSS_CFG_SVH

// register indices; byte address is four times the index
`define IDX_RX_CONTROL      6'h10
`define IDX_TX_LINE_CONTROL 6'h11
`define IDX_MANUAL_GAIN     6'h12
`define IDX_LINE_STATUS     6'h13
`define IDX_IRQ_STATUS      6'h14
`define IDX_IRQ_MASK        6'h15
`define IDX_CUSTOM_LEVEL_0  6'h1c
`define IDX_CUSTOM_LEVEL_3  6'h1f

// rx control fields
`define RXC_E1_MODE       0
`define RXC_AUTO_GAIN     1
`define RXC_THRESH_40DB   2
`define RXC_ZERO_192      3
`define RXC_PIN_ON_LOSS   4
`define RXC_PIN_ON_FRAME  5
`define RXC_RESET         8'h00

// tx line control fields
`define TXC_BUILDOUT_LSB  0
`define TXC_BUILDOUT_MSB  2
`define TXC_CUSTOM        3
`define TXC_RESET         8'h00

// interrupt status bits
`define IRQ_LOSS_SET      0
`define IRQ_LOSS_CLEAR    1
`define IRQ_FRAME_LOST    2
`define IRQ_WIDTH         3

// timing
`define ANALOG_LOSS_TIME_US 1000
`define CLK_MHZ             250
`define ZERO_LIMIT_E1_LOW   32
`define ZERO_LIMIT_E1_HIGH  192
`define ZERO_LIMIT_T1       192
`define GAIN_WIDTH          4
`define GAIN_RESET          4'h0
`define TX_PHASES           4
`define TX_CLK_DIV          4
`define GAIN_STEP_DIV       1024

`endif

// ### logic/line_loss_detect_and_pulse_shaper.sv
// receive loss detection, gain control, bit sampling and transmit pulse shaping
// How it works
// - level below selected analog threshold for 1 ms sets the loss flag
// - consecutive zeros beyond threshold set the loss flag; e1 picks 32 or 192
// - e1 analog threshold selects between -20 dB and -40 dB comparator
// - loss pin asserts on any chosen mix of signal loss and frame loss
// - equaliser gain comes from software or steps automatically from peak detectors
// - recovered line clock rising edge samples the data comparator output
// - each pulse reads level codes from rom at a fast rate into the dac
// - custom bit of tx line control selects custom level registers over rom
// - custom register values drive the dac code directly
// - three build-out bits select pulse shaping for t1 cable length or attenuation
// - build-out bits reset to zero
//
// Design decision made here: register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "line_loss_cfg.svh"
module line_loss_detect_and_pulse_shaper #(
    parameter int unsigned ANALOG_LOSS_CYCLES = `ANALOG_LOSS_TIME_US * `CLK_MHZ,
    parameter int unsigned TX_CLK_DIV         = `TX_CLK_DIV,
    parameter int unsigned GAIN_STEP_DIV      = `GAIN_STEP_DIV
) (
    input  wire logic                   clk,
    input  wire logic                   rst_n,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [7:0]             paddr,
    input  wire logic [31:0]            pwdata,
    output      logic [31:0]            prdata,
    output      logic                   pready,
    output      logic                   pslverr,
    output      logic                   irq,
    input  wire logic                   belowThresh20,
    input  wire logic                   belowThresh40,
    input  wire logic                   peakHigh,
    input  wire logic                   peakLow,
    input  wire logic                   recoveredClk,
    input  wire logic                   dataComparator,
    input  wire logic                   frameSyncLost,
    output      logic [`GAIN_WIDTH-1:0] eqGain,
    output      logic                   rxBit,
    output      logic                   rxBitValid,
    output      logic                   loss_indicator_pin,
    input  wire logic                   txMark,
    input  wire logic                   txPolarity,
    output      logic                   txReady,
    output      line_loss_pkg::level_t  dacCode,
    output      logic                   tx_line_positive,
    output      logic                   tx_line_negative
);
    // pin synchronisers
    logic [5:0] syncA_reg;
    logic [5:0] syncB_reg;
    logic       clkSeen_reg;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            syncA_reg   <= 6'h00;
            syncB_reg   <= 6'h00;
            clkSeen_reg <= 1'b0;
        end else begin
            syncA_reg   <= {belowThresh20, belowThresh40, peakHigh, peakLow,
                            recoveredClk, dataComparator};
            syncB_reg   <= syncA_reg;
            clkSeen_reg <= syncB_reg[1];
        end
    end
    logic below20S, below40S, peakHighS, peakLowS, rxClkS, rxDataS;
    assign {below20S, below40S, peakHighS, peakLowS, rxClkS, rxDataS} = syncB_reg;

    // register file
    logic [7:0]               rxControl_reg,   rxControl_next;
    logic [7:0]               txControl_reg,   txControl_next;
    logic [`GAIN_WIDTH-1:0]   manualGain_reg,  manualGain_next;
    logic [`IRQ_WIDTH-1:0]    irqStatus_reg,   irqStatus_next;
    logic [`IRQ_WIDTH-1:0]    irqMask_reg,     irqMask_next;
    line_loss_pkg::level_t    custom_reg [4];
    line_loss_pkg::level_t    custom_next [4];
    logic [31:0]              prdata_reg,      prdata_next;
    logic [`IRQ_WIDTH-1:0]    irqEvents;
    logic                     lineLost;

    logic [5:0] regIdx;
    logic       aligned;
    logic       mapped;
    logic       setupPhase;
    logic       writeDone;
    assign regIdx     = paddr[7:2];
    assign aligned    = (paddr[1:0] == 2'h0);
    assign mapped     = aligned && ((regIdx >= `IDX_RX_CONTROL && regIdx <= `IDX_IRQ_MASK) ||
                        (regIdx >= `IDX_CUSTOM_LEVEL_0 && regIdx <= `IDX_CUSTOM_LEVEL_3));
    assign setupPhase = psel && !penable;
    assign writeDone  = psel && penable && pwrite && mapped;

    // zero wait states: read data is captured in the setup cycle
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped;

    always_comb begin
        rxControl_next  = rxControl_reg;
        txControl_next  = txControl_reg;
        manualGain_next = manualGain_reg;
        irqMask_next    = irqMask_reg;
        irqStatus_next  = irqStatus_reg;
        prdata_next     = prdata_reg;
        for (int i = 0; i < 4; i++) begin
            custom_next[i] = custom_reg[i];
        end
        if (writeDone) begin
            case (regIdx)
                `IDX_RX_CONTROL:      rxControl_next  = pwdata[7:0];
                `IDX_TX_LINE_CONTROL: txControl_next  = pwdata[7:0];
                `IDX_MANUAL_GAIN:     manualGain_next = pwdata[`GAIN_WIDTH-1:0];
                `IDX_IRQ_STATUS:      irqStatus_next  = irqStatus_reg & ~pwdata[`IRQ_WIDTH-1:0];
                `IDX_IRQ_MASK:        irqMask_next    = pwdata[`IRQ_WIDTH-1:0];
                default: begin
                    if (regIdx >= `IDX_CUSTOM_LEVEL_0) begin
                        custom_next[regIdx[1:0]] = pwdata[7:0];
                    end
                end
            endcase
        end
        // an event in the clearing cycle survives
        irqStatus_next = irqStatus_next | irqEvents;
        if (setupPhase && !pwrite) begin
            prdata_next = 32'h0000_0000;
            case (regIdx)
                `IDX_RX_CONTROL:      prdata_next[7:0] = rxControl_reg;
                `IDX_TX_LINE_CONTROL: prdata_next[7:0] = txControl_reg;
                `IDX_MANUAL_GAIN:     prdata_next[`GAIN_WIDTH-1:0] = manualGain_reg;
                `IDX_LINE_STATUS:     prdata_next[`GAIN_WIDTH+1:0] =
                                          {eqGain, frameSyncLost, lineLost};
                `IDX_IRQ_STATUS:      prdata_next[`IRQ_WIDTH-1:0] = irqStatus_reg;
                `IDX_IRQ_MASK:        prdata_next[`IRQ_WIDTH-1:0] = irqMask_reg;
                default: begin
                    if (regIdx >= `IDX_CUSTOM_LEVEL_0 && regIdx <= `IDX_CUSTOM_LEVEL_3) begin
                        prdata_next[7:0] = custom_reg[regIdx[1:0]];
                    end
                end
            endcase
            if (!aligned) begin
                prdata_next = 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rxControl_reg  <= `RXC_RESET;
            txControl_reg  <= `TXC_RESET;
            manualGain_reg <= `GAIN_RESET;
            irqStatus_reg  <= '0;
            irqMask_reg    <= '0;
            prdata_reg     <= 32'h0000_0000;
            for (int i = 0; i < 4; i++) begin
                custom_reg[i] <= 8'h00;
            end
        end else begin
            rxControl_reg  <= rxControl_next;
            txControl_reg  <= txControl_next;
            manualGain_reg <= manualGain_next;
            irqStatus_reg  <= irqStatus_next;
            irqMask_reg    <= irqMask_next;
            prdata_reg     <= prdata_next;
            for (int i = 0; i < 4; i++) begin
                custom_reg[i] <= custom_next[i];
            end
        end
    end
    assign prdata = prdata_reg;
    assign irq    = |(irqStatus_reg & irqMask_reg);

    // receive side
    localparam int unsigned AW = $clog2(ANALOG_LOSS_CYCLES + 1);
    localparam int unsigned GW = $clog2(GAIN_STEP_DIV + 1);
    logic [AW-1:0]          lowCount_reg,   lowCount_next;
    logic [7:0]             zeroCount_reg,  zeroCount_next;
    logic [GW-1:0]          gainTick_reg,   gainTick_next;
    logic [`GAIN_WIDTH-1:0] autoGain_reg,   autoGain_next;
    logic                   analogLost_reg, analogLost_next;
    logic                   zeroLost_reg,   zeroLost_next;
    logic                   rxBit_reg,      rxBit_next;
    logic                   rxValid_reg,    rxValid_next;
    logic                   lineLost_reg;
    logic                   frameLost_reg;
    logic                   isE1;
    logic                   belowSel;
    logic [7:0]             zeroLimit;
    logic                   rxEdge;

    assign isE1     = rxControl_reg[`RXC_E1_MODE];
    // t1 uses the -20 dB comparator only
    assign belowSel = (isE1 && rxControl_reg[`RXC_THRESH_40DB]) ? below40S : below20S;
    assign zeroLimit = !isE1 ? 8'(`ZERO_LIMIT_T1) :
                       rxControl_reg[`RXC_ZERO_192] ? 8'(`ZERO_LIMIT_E1_HIGH) :
                                                      8'(`ZERO_LIMIT_E1_LOW);
    assign rxEdge   = rxClkS && !clkSeen_reg;

    always_comb begin
        lowCount_next   = lowCount_reg;
        analogLost_next = analogLost_reg;
        zeroCount_next  = zeroCount_reg;
        zeroLost_next   = zeroLost_reg;
        gainTick_next   = gainTick_reg + GW'(1);
        autoGain_next   = autoGain_reg;
        rxBit_next      = rxBit_reg;
        rxValid_next    = 1'b0;
        // one good sample ends the analog timeout at once
        if (!belowSel) begin
            lowCount_next   = '0;
            analogLost_next = 1'b0;
        end else if (lowCount_reg >= AW'(ANALOG_LOSS_CYCLES - 1)) begin
            analogLost_next = 1'b1;
        end else begin
            lowCount_next = lowCount_reg + AW'(1);
        end
        if (rxEdge) begin
            rxBit_next   = rxDataS;
            rxValid_next = 1'b1;
            if (rxDataS) begin
                zeroCount_next = 8'h00;
                zeroLost_next  = 1'b0;
            end else begin
                // saturates so a long silence keeps the flag up
                if (zeroCount_reg != 8'hff) begin
                    zeroCount_next = zeroCount_reg + 8'h01;
                end
                if (zeroCount_reg >= zeroLimit) begin
                    zeroLost_next = 1'b1;
                end
            end
        end
        // slow stepping keeps the gain loop from chasing single pulses
        if (gainTick_reg >= GW'(GAIN_STEP_DIV - 1)) begin
            gainTick_next = '0;
            if (peakHighS && autoGain_reg != '0) begin
                autoGain_next = autoGain_reg - (`GAIN_WIDTH)'(1);
            end else if (peakLowS && autoGain_reg != '1) begin
                autoGain_next = autoGain_reg + (`GAIN_WIDTH)'(1);
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lowCount_reg   <= '0;
            analogLost_reg <= 1'b0;
            zeroCount_reg  <= 8'h00;
            zeroLost_reg   <= 1'b0;
            gainTick_reg   <= '0;
            autoGain_reg   <= `GAIN_RESET;
            rxBit_reg      <= 1'b0;
            rxValid_reg    <= 1'b0;
            lineLost_reg   <= 1'b0;
            frameLost_reg  <= 1'b0;
        end else begin
            lowCount_reg   <= lowCount_next;
            analogLost_reg <= analogLost_next;
            zeroCount_reg  <= zeroCount_next;
            zeroLost_reg   <= zeroLost_next;
            gainTick_reg   <= gainTick_next;
            autoGain_reg   <= autoGain_next;
            rxBit_reg      <= rxBit_next;
            rxValid_reg    <= rxValid_next;
            lineLost_reg   <= lineLost;
            frameLost_reg  <= frameSyncLost;
        end
    end

    assign lineLost   = analogLost_reg || zeroLost_reg;
    assign rxBit      = rxBit_reg;
    assign rxBitValid = rxValid_reg;
    assign eqGain     = rxControl_reg[`RXC_AUTO_GAIN] ? autoGain_reg : manualGain_reg;
    assign loss_indicator_pin = (rxControl_reg[`RXC_PIN_ON_LOSS]  && lineLost) ||
                                (rxControl_reg[`RXC_PIN_ON_FRAME] && frameSyncLost);
    assign irqEvents[`IRQ_LOSS_SET]   = lineLost && !lineLost_reg;
    assign irqEvents[`IRQ_LOSS_CLEAR] = !lineLost && lineLost_reg;
    assign irqEvents[`IRQ_FRAME_LOST] = frameSyncLost && !frameLost_reg;

    // transmit side
    localparam int unsigned DW = $clog2(TX_CLK_DIV + 1);
    line_loss_pkg::tx_state_e txState_reg, txState_next;
    logic [DW-1:0]            txDiv_reg,   txDiv_next;
    logic [1:0]               phase_reg,   phase_next;
    logic                     pol_reg,     pol_next;
    line_loss_pkg::level_t    dac_reg,     dac_next;
    logic                     pos_reg,     pos_next;
    logic                     neg_reg,     neg_next;
    line_loss_pkg::level_t    romData;
    logic                     fastTick;

    assign fastTick = (txDiv_reg >= DW'(TX_CLK_DIV - 1));

    // rom is read every cycle; phase holds for the divider period so data has settled
    pulse_rom u_rom (
        .clk  (clk),
        .addr ({isE1, txControl_reg[`TXC_BUILDOUT_MSB:`TXC_BUILDOUT_LSB], phase_reg}),
        .data (romData)
    );

    always_comb begin
        txState_next = txState_reg;
        txDiv_next   = fastTick ? '0 : txDiv_reg + DW'(1);
        phase_next   = phase_reg;
        pol_next     = pol_reg;
        dac_next     = dac_reg;
        pos_next     = pos_reg;
        neg_next     = neg_reg;
        case (txState_reg)
            line_loss_pkg::TX_IDLE: begin
                if (txMark) begin
                    txState_next = line_loss_pkg::TX_SHAPE;
                    pol_next     = txPolarity;
                    phase_next   = 2'h0;
                    txDiv_next   = '0;
                end
            end
            line_loss_pkg::TX_SHAPE: begin
                if (fastTick) begin
                    dac_next = txControl_reg[`TXC_CUSTOM] ? custom_reg[phase_reg]
                                                          : romData;
                    pos_next = !pol_reg;
                    neg_next = pol_reg;
                    if (phase_reg == 2'(`TX_PHASES - 1)) begin
                        txState_next = line_loss_pkg::TX_IDLE;
                    end else begin
                        phase_next = phase_reg + 2'h1;
                    end
                end
            end
            default: txState_next = line_loss_pkg::TX_IDLE;
        endcase
        // drivers fall quiet once the last level has been held one slot
        if (txReady && fastTick && !txMark) begin
            dac_next = 8'h00;
            pos_next = 1'b0;
            neg_next = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            txState_reg <= line_loss_pkg::TX_IDLE;
            txDiv_reg   <= '0;
            phase_reg   <= 2'h0;
            pol_reg     <= 1'b0;
            dac_reg     <= 8'h00;
            pos_reg     <= 1'b0;
            neg_reg     <= 1'b0;
        end else begin
            txState_reg <= txState_next;
            txDiv_reg   <= txDiv_next;
            phase_reg   <= phase_next;
            pol_reg     <= pol_next;
            dac_reg     <= dac_next;
            pos_reg     <= pos_next;
            neg_reg     <= neg_next;
        end
    end

    assign txReady          = (txState_reg == line_loss_pkg::TX_IDLE);
    assign dacCode          = dac_reg;
    assign tx_line_positive = pos_reg;
    assign tx_line_negative = neg_reg;
endmodule : line_loss_detect_and_pulse_shaper
`default_nettype wire

// ### logic/line_loss_pkg.sv
// types shared by the line loss and pulse shaping block
package line_loss_pkg;
    typedef enum logic [0:0] {TX_IDLE, TX_SHAPE} tx_state_e;
    typedef logic [7:0] level_t;
    typedef logic [5:0] rom_addr_t;
endpackage : line_loss_pkg

// ### logic/pulse_rom.sv
// pulse shape rom: level code per mode, build-out and phase, registered read
`timescale 1ns/1ps
`default_nettype none
module pulse_rom (
    input  wire logic                    clk,
    input  wire line_loss_pkg::rom_addr_t addr,
    output      line_loss_pkg::level_t   data
);
    line_loss_pkg::level_t table_mem [0:63];
    line_loss_pkg::level_t data_reg;

    // base level per phase, lowered by build-out; flatter e1 top
    function automatic line_loss_pkg::level_t shape(input logic [5:0] a);
        logic [7:0] base;
        base = 8'h00;
        case (a[1:0])
            2'h0:    base = a[5] ? 8'h70 : 8'h60;
            2'h1:    base = 8'h7f;
            2'h2:    base = a[5] ? 8'h70 : 8'h48;
            default: base = 8'h10;
        endcase
        return base - {2'h0, a[4:2], 3'h0};
    endfunction : shape

    generate
        for (genvar i = 0; i < 64; i++) begin : g_fill
            assign table_mem[i] = shape(6'(i));
        end
    endgenerate

    always_ff @(posedge clk) begin
        data_reg <= table_mem[addr];
    end
    assign data = data_reg;
endmodule : pulse_rom
`default_nettype wire

// ### sim/line_front_model.sv
// behavioural analog front end: comparators, peak detectors, recovered clock
`timescale 1ns/1ps
`default_nettype none
module line_front_model (
    input  wire logic clk,
    output var  logic belowThresh20,
    output var  logic belowThresh40,
    output var  logic peakHigh,
    output var  logic peakLow,
    output var  logic recoveredClk,
    output var  logic dataComparator
);
    initial begin
        {belowThresh20, belowThresh40, peakHigh, peakLow, recoveredClk, dataComparator} = '0;
    end
    // data flips after the high phase so a late sample would read the wrong bit
    task sendBit(input logic b);
        @(posedge clk);
        dataComparator <= b;
        repeat (2) @(posedge clk);
        recoveredClk <= 1'b1;
        repeat (3) @(posedge clk);
        recoveredClk <= 1'b0;
        dataComparator <= ~b;
        repeat (2) @(posedge clk);
    endtask : sendBit
    task setLevel(input logic b20, input logic b40);
        @(posedge clk);
        belowThresh20 <= b20;
        belowThresh40 <= b40;
    endtask : setLevel
    task setPeak(input logic hi, input logic lo);
        @(posedge clk);
        peakHigh <= hi;
        peakLow <= lo;
    endtask : setPeak
endmodule : line_front_model
`default_nettype wire

// ### sim/line_loss_properties.sv
// port level checks for the line loss and pulse block
`timescale 1ns/1ps
`default_nettype none
module line_loss_properties (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        recoveredClk,
    input wire logic        dataComparator,
    input wire logic        rxBit,
    input wire logic        rxBitValid,
    input wire logic        txMark,
    input wire logic        txReady,
    input wire logic [7:0]  dacCode,
    input wire logic        tx_line_positive,
    input wire logic        tx_line_negative
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_ready_high: assert property (pready) else $error("pready low");
    a_err_misalign: assert property (psel && penable && paddr[1:0] != 2'h0 |-> pslverr)
        else $error("misaligned access not refused");
    a_err_phase: assert property (pslverr |-> psel && penable) else $error("stray pslverr");
    a_err_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0)
        else $error("refused read not zero");
    a_valid_pulse: assert property (rxBitValid |=> !rxBitValid) else $error("valid too long");
    a_valid_cause: assert property (rxBitValid |-> $past(recoveredClk, 3) &&
        rxBit == $past(dataComparator, 3)) else $error("bit not from clock edge");
    a_take_busy: assert property (txMark && txReady |=> !txReady [*8]) else $error("short pulse");
    a_drv_excl: assert property (!(tx_line_positive && tx_line_negative))
        else $error("both drivers on");
    a_idle_zero: assert property (txReady [*8] |-> dacCode == 8'h00 && !tx_line_positive)
        else $error("dac not idle");
    c_rx_bit: cover property (rxBitValid);
    c_tx_take: cover property (txMark && txReady);
    c_refused: cover property (pslverr);
endmodule : line_loss_properties
bind line_loss_detect_and_pulse_shaper line_loss_properties chk (.clk, .rst_n, .psel,
    .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .recoveredClk, .dataComparator,
    .rxBit, .rxBitValid, .txMark, .txReady, .dacCode, .tx_line_positive, .tx_line_negative);
`default_nettype wire

// ### sim/test_line_loss_detect_and_pulse_shaper.sv
// directed bench for the line loss and pulse block
`timescale 1ns/1ps
`default_nettype none
`include "line_loss_cfg.svh"
module test_line_loss_detect_and_pulse_shaper;
    localparam int ALC = 20, TXD = 4, GSD = 8;
    localparam logic [7:0] A_RXC = {`IDX_RX_CONTROL, 2'b00};
    localparam logic [7:0] A_TXC = {`IDX_TX_LINE_CONTROL, 2'b00};
    localparam logic [7:0] A_GAIN = {`IDX_MANUAL_GAIN, 2'b00};
    localparam logic [7:0] A_IRQ = {`IDX_IRQ_STATUS, 2'b00};
    localparam logic [7:0] A_MASK = {`IDX_IRQ_MASK, 2'b00};
    localparam logic [7:0] A_CL0 = {`IDX_CUSTOM_LEVEL_0, 2'b00};
    localparam logic [31:0] LV = 32'h44332211;
    logic clk, rst_n, psel, penable, pwrite, pready, pslverr, irq, lastErr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic belowThresh20, belowThresh40, peakHigh, peakLow, recoveredClk, dataComparator;
    logic frameSyncLost, rxBit, rxBitValid, loss_indicator_pin, txMark, txPolarity, txReady;
    logic tx_line_positive, tx_line_negative;
    logic [`GAIN_WIDTH-1:0] eqGain;
    line_loss_pkg::level_t dacCode;
    int err_count, check_count, cyc;
    line_loss_detect_and_pulse_shaper #(.ANALOG_LOSS_CYCLES(ALC), .TX_CLK_DIV(TXD),
        .GAIN_STEP_DIV(GSD)) uut (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .irq, .belowThresh20, .belowThresh40, .peakHigh,
        .peakLow, .recoveredClk, .dataComparator, .frameSyncLost, .eqGain, .rxBit,
        .rxBitValid, .loss_indicator_pin, .txMark, .txPolarity, .txReady, .dacCode,
        .tx_line_positive, .tx_line_negative);
    line_front_model fm (.clk, .belowThresh20, .belowThresh40, .peakHigh, .peakLow,
        .recoveredClk, .dataComparator);
    task summarize();
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : summarize
    task check(input string nm, input logic [31:0] e, s);
        check_count++;
        if (s !== e) begin
            err_count++;
            $display("FAIL %s expected %h seen %h", nm, e, s);
        end
    endtask : check
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rdat = prdata;
        lastErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task rdChk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        check($sformatf("reg %h", a), e, rdat);
    endtask : rdChk
    task rxCheck(input logic b);
        fork
            fm.sendBit(b);
            @(posedge clk iff rxBitValid === 1'b1);
        join
        check("rx bit", b, rxBit);
    endtask : rxCheck
    task chkPin(input logic e);
        repeat (2) @(posedge clk);
        #1 check("loss pin", e, loss_indicator_pin);
    endtask : chkPin
    task txSend(input logic p, input logic [31:0] lv, input logic c);
        @(posedge clk);
        txMark <= 1'b1;
        txPolarity <= p;
        @(posedge clk);
        txMark <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            repeat (TXD) @(posedge clk);
            #1;
            if (c) begin
                check("dac", lv[8*i+:8], dacCode);
                check("drivers", {p, ~p}, {tx_line_negative, tx_line_positive});
            end
        end
        repeat (2 * TXD) @(posedge clk);
        #1 check("tx ready", 1, txReady);
    endtask : txSend
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // a hang anywhere ends in the same report
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            summarize();
        end
    end
    initial begin
        {rst_n, psel, penable, pwrite, frameSyncLost, txMark, txPolarity, paddr, pwdata} = '0;
        {err_count, check_count} = '0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        rdChk(A_TXC, 32'h0);
        rdChk(A_RXC, 32'h0);
        rdChk(A_CL0, 32'h0);
        apb(1'b0, 8'h45, 32'h0);
        check("slverr", 1, lastErr);
        check("refused read", 0, rdat);
        for (int i = 0; i < 8; i++) begin
            apb(1'b1, A_TXC, i);
            rdChk(A_TXC, i);
            txSend(i[0], 32'h0, 1'b0);
        end
        for (int i = 0; i < 4; i++) apb(1'b1, A_CL0 + 8'(4 * i), 32'(8'h11 * (i + 1)));
        apb(1'b1, A_TXC, 32'h08);
        txSend(1'b0, LV, 1'b1);
        txSend(1'b1, LV, 1'b1);
        apb(1'b1, A_RXC, 32'h11);
        apb(1'b1, A_MASK, 32'h1);
        rxCheck(1'b1);
        apb(1'b1, A_IRQ, 32'h7);
        repeat (32) rxCheck(1'b0);
        chkPin(1'b0);
        rxCheck(1'b0);
        chkPin(1'b1);
        check("irq", 1, irq);
        rdChk({`IDX_LINE_STATUS, 2'b00}, 32'h1);
        rdChk(A_IRQ, 32'h1);
        apb(1'b1, A_MASK, 32'h0);
        #1 check("irq masked", 0, irq);
        apb(1'b1, A_MASK, 32'h1);
        apb(1'b1, A_IRQ, 32'h1);
        #1 check("irq cleared", 0, irq);
        for (int c = 0; c < 4; c++) begin
            for (int f = 0; f < 2; f++) begin
                apb(1'b1, A_RXC, 32'h1 | (c << 4));
                frameSyncLost <= f[0];
                @(posedge clk);
                #1 check("pin mix", c[0] | (c[1] & f[0]), loss_indicator_pin);
            end
        end
        @(posedge clk);
        frameSyncLost <= 1'b0;
        rxCheck(1'b1);
        chkPin(1'b0);
        rdChk(A_IRQ, 32'h6);
        apb(1'b1, A_RXC, 32'h19);
        repeat (192) rxCheck(1'b0);
        chkPin(1'b0);
        rxCheck(1'b0);
        chkPin(1'b1);
        rxCheck(1'b1);
        apb(1'b1, A_RXC, 32'h15);
        fm.setLevel(1'b1, 1'b0);
        repeat (ALC + 10) @(posedge clk);
        chkPin(1'b0);
        apb(1'b1, A_RXC, 32'h11);
        repeat (ALC - 4) @(posedge clk);
        chkPin(1'b0);
        repeat (10) @(posedge clk);
        chkPin(1'b1);
        fm.setLevel(1'b0, 1'b0);
        repeat (4) @(posedge clk);
        chkPin(1'b0);
        apb(1'b1, A_GAIN, 32'h5);
        #1 check("manual gain", 5, eqGain);
        apb(1'b1, A_RXC, 32'h2);
        fm.setPeak(1'b0, 1'b1);
        repeat (20 * GSD) @(posedge clk);
        #1 check("gain up", 15, eqGain);
        fm.setPeak(1'b1, 1'b0);
        repeat (20 * GSD) @(posedge clk);
        #1 check("gain down", 0, eqGain);
        summarize();
    end
endmodule : test_line_loss_detect_and_pulse_shaper
`default_nettype wire
